// *** logic/qpt_pkg.sv ***
// package for the quad prescaled down timers
// assumes one 200 MHz system clock and an AXI4-Lite register master
package qpt_pkg;

	// -----------------------------------------------------------------
	// register map, byte addresses
	// -----------------------------------------------------------------
	localparam logic [31:0] OFS_CTRL_A   = 32'h0000_0000; // timer_a_control
	localparam logic [31:0] OFS_CTRL_B   = 32'h0000_0004; // timer_b_control
	localparam logic [31:0] OFS_CTRL_CD  = 32'h0000_0008; // delay_timers_control
	localparam logic [31:0] OFS_DATA_A   = 32'h0000_000C; // timer_a_count_constant
	localparam logic [31:0] OFS_DATA_B   = 32'h0000_0010; // timer_b_count_constant
	localparam logic [31:0] OFS_DATA_C   = 32'h0000_0014; // timer_c_count_constant
	localparam logic [31:0] OFS_DATA_D   = 32'h0000_0018; // timer_d_count_constant
	localparam logic [31:0] OFS_EDGE_POL = 32'h0000_001C; // edge_polarity_register

	// -----------------------------------------------------------------
	// field layout
	// -----------------------------------------------------------------
	localparam int          CTRL_OUT_RESET_BIT = 4;  // output reset in A/B ctrl
	localparam int          CD_BAUD_SHARE_BIT  = 7;  // both baud clocks from C
	localparam int          CD_C_LSB           = 4;  // timer C code position
	localparam int          CD_D_LSB           = 0;  // timer D code position
	localparam logic [7:0]  COUNT_ONE          = 8'h01;
	localparam logic [7:0]  COUNT_STEP         = 8'h01;
	localparam logic [3:0]  CTRL_RESET         = 4'h0;
	localparam logic [7:0]  CD_RESET           = 8'h00;
	localparam logic [1:0]  POL_RESET          = 2'h0;
	localparam logic [1:0]  RESP_OKAY          = 2'h0;
	localparam logic [1:0]  RESP_DECERR        = 2'h3;

	// -----------------------------------------------------------------
	// modes and the code to mode and divide mapping
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_STOP  = 2'h0,
		MODE_DELAY = 2'h1,
		MODE_EVENT = 2'h2,
		MODE_PWM   = 2'h3
	} qpt_mode_type;

	typedef qpt_mode_type [15:0]   qpt_mode_map_type;  // per 4-bit code
	typedef logic [7:0][7:0]       qpt_div_table_type; // by code[2:0]

	localparam qpt_mode_map_type MODE_MAP_DEFAULT = {
		{7{MODE_PWM}}, MODE_EVENT, {7{MODE_DELAY}}, MODE_STOP};
	localparam qpt_div_table_type DIV_TABLE_DEFAULT = {
		8'hC8, 8'h64, 8'h40, 8'h32, 8'h10, 8'h0A, 8'h04, 8'h01};

	// -----------------------------------------------------------------
	// AXI4-Lite carriers
	// -----------------------------------------------------------------
	typedef struct packed {
		logic        awvalid;
		logic [31:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [31:0] araddr;
		logic        rready;
	} qpt_axi_req_type;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} qpt_axi_rsp_type;

endpackage : qpt_pkg

// *** logic/qpt_timers.sv ***
// four prescaled 8-bit down timers with an AXI4-Lite register slave
// assumes clk_sys at 200 MHz; timer oscillator and aux pins are async
//
// Operation
// RULE1 - four timers, A/B full modes, C/D delay
// RULE2 - C/D outputs serve as serial baud clocks
// RULE3 - one shared timer clock from oscillator pin
// RULE4 - each timer output toggles on time-out
// RULE5 - stopped: counter holds, prescaler residue dropped
// RULE6 - delay mode: prescaler pulses every N clocks
// RULE7 - each count pulse decrements the counter
// RULE8 - at 01 next pulse reloads, signals time-out
// RULE9 - time-out pulses go to interrupt channel
// RULE10 - output holds level until next time-out
// RULE11 - 8-bit down counter, readable anytime
// RULE12 - read returns value captured before read
// RULE13 - stopped write loads constant and counter
// RULE14 - running write loads constant only
// RULE15 - host avoids writing running timer at 01
// RULE16 - constant 01 times out every pulse
// RULE17 - constant 00 gives 256 pulses per time-out
// RULE18 - unused A/B control bits read zero
// RULE19 - control picks mode, data reads/writes count
// RULE20 - aux inputs: event source, pulse-width gate
// RULE21 - pulse-width: run only while aux active
// RULE22 - event mode: aux active edge counts once
// RULE23 - reset drives outputs low, keeps counts
// RULE24 - output reset bit holds output low; code only clears the output on that write, the bit is not stored
// RULE25 - code to mode/divide mapping is parameter
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
module qpt_timers #(
	parameter qpt_pkg::qpt_mode_map_type  MODE_MAP  =
		qpt_pkg::MODE_MAP_DEFAULT,            // code to mode
	parameter qpt_pkg::qpt_div_table_type DIV_TABLE =
		qpt_pkg::DIV_TABLE_DEFAULT            // code[2:0] to divide
) (
	input  wire logic                     clk_sys,     // system clock
	input  wire logic                     nrst,        // async reset, low
	input  wire qpt_pkg::qpt_axi_req_type axiReq,      // bus master side
	output      qpt_pkg::qpt_axi_rsp_type axiRsp,      // bus slave side
	input  wire logic                     timerOscIn,  // timer clock pin
	output      logic                     timerOscOut, // oscillator drive
	input  wire logic                     timerAAuxIn, // timer A aux pin
	input  wire logic                     timerBAuxIn, // timer B aux pin
	output      logic [3:0]               timerOut,    // time-out outputs
	output      logic [3:0]               timeoutPulse,// to irq channels
	output      logic                     txBaudClk,   // serial tx clock
	output      logic                     rxBaudClk    // serial rx clock
);

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	typedef struct packed {
		logic [2:0]      oscSync;   // sync pair plus previous
		logic [1:0][2:0] auxSync;   // per aux pin: sync pair plus previous
		logic [3:0]      ctrlA;
		logic [3:0]      ctrlB;
		logic [7:0]      ctrlCD;
		logic [1:0]      edgePol;
		logic [3:0][7:0] presc;
		logic [3:0][7:0] cnt;
		logic [3:0][7:0] tconst;
		logic [3:0][7:0] hold;      // read holding registers
		logic [3:0]      tOut;
		logic [3:0]      tPulse;
		logic            txClk;
		logic            rxClk;
		logic            oscOut;
		logic            awHeld;
		logic [31:0]     awAddr;
		logic            wHeld;
		logic [7:0]      wData;
		logic            wLane0;
		logic            awready;
		logic            wready;
		logic            bvalid;
		logic [1:0]      bresp;
		logic            arready;
		logic            rvalid;
		logic [31:0]     rdata;
		logic [1:0]      rresp;
	} qpt_state_type;

	qpt_state_type state_q;
	qpt_state_type state_d;
	logic [1:0]    rstSync_q;
	logic          rstN;

	// -----------------------------------------------------------------
	// reset release through two flip-flops
	// -----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rstSync_q <= 2'h0;
		end else begin
			rstSync_q <= {rstSync_q[0], 1'b1};
		end
	end
	assign rstN = rstSync_q[1];

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	always_comb begin
		logic                 oscTick;
		logic                 doWrite;
		logic                 wrOk;
		logic [7:0]           rdByte;
		logic                 rdOk;
		logic [3:0]           code;
		qpt_pkg::qpt_mode_type mode;
		logic [7:0]           divide;
		logic                 auxLvl;
		logic                 auxPrev;
		logic                 countPulse;
		logic                 dataWr;
		logic [7:0]           nextPresc;
		oscTick    = 1'b0;
		doWrite    = 1'b0;
		wrOk       = 1'b0;
		rdByte     = 8'h00;
		rdOk       = 1'b0;
		code       = 4'h0;
		mode       = qpt_pkg::MODE_STOP;
		divide     = 8'h01;
		auxLvl     = 1'b0;
		auxPrev    = 1'b0;
		countPulse = 1'b0;
		dataWr     = 1'b0;
		nextPresc  = 8'h00;
		state_d    = state_q;

		// pin synchronisers; the timer clock edge is a one-cycle tick
		state_d.oscSync = {state_q.oscSync[1:0], timerOscIn}; // see RULE3
		state_d.auxSync[0] = {state_q.auxSync[0][1:0], timerAAuxIn};
		state_d.auxSync[1] = {state_q.auxSync[1][1:0], timerBAuxIn};
		oscTick = state_q.oscSync[1] & ~state_q.oscSync[2]; // see RULE3
		state_d.oscOut = ~state_q.oscSync[1];

		// write channel: address and data taken in either order
		if (axiReq.awvalid && state_q.awready) begin
			state_d.awHeld = 1'b1;
			state_d.awAddr = axiReq.awaddr;
		end
		if (axiReq.wvalid && state_q.wready) begin
			state_d.wHeld  = 1'b1;
			state_d.wData  = axiReq.wdata[7:0];
			state_d.wLane0 = axiReq.wstrb[0];
		end
		if (state_q.bvalid && axiReq.bready) begin
			state_d.bvalid = 1'b0;
		end
		doWrite = state_q.awHeld && state_q.wHeld && !state_q.bvalid;
		if (doWrite) begin
			state_d.awHeld = 1'b0;
			state_d.wHeld  = 1'b0;
			state_d.bvalid = 1'b1;
			wrOk = (state_q.awAddr == qpt_pkg::OFS_CTRL_A)
				|| (state_q.awAddr == qpt_pkg::OFS_CTRL_B)
				|| (state_q.awAddr == qpt_pkg::OFS_CTRL_CD)
				|| (state_q.awAddr == qpt_pkg::OFS_DATA_A)
				|| (state_q.awAddr == qpt_pkg::OFS_DATA_B)
				|| (state_q.awAddr == qpt_pkg::OFS_DATA_C)
				|| (state_q.awAddr == qpt_pkg::OFS_DATA_D)
				|| (state_q.awAddr == qpt_pkg::OFS_EDGE_POL);
			state_d.bresp = wrOk ? qpt_pkg::RESP_OKAY
				: qpt_pkg::RESP_DECERR;
		end
		state_d.awready = !state_d.awHeld && !state_d.bvalid;
		state_d.wready  = !state_d.wHeld && !state_d.bvalid;

		// control register writes; upper A/B bits are not stored
		if (doWrite && state_q.wLane0) begin
			case (state_q.awAddr)
				qpt_pkg::OFS_CTRL_A: begin
					state_d.ctrlA = state_q.wData[3:0]; // see RULE19
				end
				qpt_pkg::OFS_CTRL_B: begin
					state_d.ctrlB = state_q.wData[3:0]; // see RULE19
				end
				qpt_pkg::OFS_CTRL_CD: begin
					state_d.ctrlCD = state_q.wData;
				end
				qpt_pkg::OFS_EDGE_POL: begin
					state_d.edgePol = state_q.wData[1:0];
				end
				default: begin
				end
			endcase
		end

		// per-timer prescaler, counter and output
		for (int i = 0; i < 4; i++) begin
			if (i < 2) begin
				code   = (i == 0) ? state_q.ctrlA : state_q.ctrlB;
				mode   = MODE_MAP[code];            // see RULE25 RULE1
				auxLvl = state_q.auxSync[i][1];
				auxPrev = state_q.auxSync[i][2];
			end else begin
				code = {1'b0, (i == 2)
					? state_q.ctrlCD[qpt_pkg::CD_C_LSB +: 3]
					: state_q.ctrlCD[qpt_pkg::CD_D_LSB +: 3]};
				mode = (code == 4'h0) ? qpt_pkg::MODE_STOP
					: qpt_pkg::MODE_DELAY;          // see RULE1
				auxLvl  = 1'b0;
				auxPrev = 1'b0;
			end
			divide     = DIV_TABLE[code[2:0]];
			countPulse = 1'b0;
			nextPresc  = state_q.presc[i] + qpt_pkg::COUNT_STEP;
			case (mode)
				qpt_pkg::MODE_DELAY: begin
					if (oscTick) begin              // see RULE6
						if (nextPresc >= divide) begin
							countPulse = 1'b1;
							state_d.presc[i] = 8'h00;
						end else begin
							state_d.presc[i] = nextPresc;
						end
					end
				end
				qpt_pkg::MODE_PWM: begin
					// gated by aux level matching polarity; else halted
					if (oscTick && auxLvl == state_q.edgePol[i]) begin
						if (nextPresc >= divide) begin // see RULE21 RULE20
							countPulse = 1'b1;
							state_d.presc[i] = 8'h00;
						end else begin
							state_d.presc[i] = nextPresc;
						end
					end
				end
				qpt_pkg::MODE_EVENT: begin
					state_d.presc[i] = 8'h00;       // prescaler bypassed
					countPulse = (auxLvl != auxPrev)
						&& (auxLvl == state_q.edgePol[i]); // see RULE22 RULE20
				end
				default: begin
					state_d.presc[i] = 8'h00;       // see RULE5
				end
			endcase

			// count pulse: decrement, or reload and time out at 01
			state_d.tPulse[i] = 1'b0;
			if (countPulse) begin
				if (state_q.cnt[i] == qpt_pkg::COUNT_ONE) begin
					state_d.cnt[i] = state_q.tconst[i]; // see RULE8 RULE16
					state_d.tPulse[i] = 1'b1;          // see RULE9
					state_d.tOut[i] = ~state_q.tOut[i]; // see RULE4 RULE10
				end else begin
					// 00 wraps to FF, giving 256 pulses per time-out
					state_d.cnt[i] = state_q.cnt[i]
						- qpt_pkg::COUNT_STEP;     // see RULE7 RULE17
				end
			end

			// data register write
			case (i)
				0: dataWr = state_q.awAddr == qpt_pkg::OFS_DATA_A;
				1: dataWr = state_q.awAddr == qpt_pkg::OFS_DATA_B;
				2: dataWr = state_q.awAddr == qpt_pkg::OFS_DATA_C;
				default: dataWr = state_q.awAddr == qpt_pkg::OFS_DATA_D;
			endcase
			if (doWrite && state_q.wLane0 && dataWr) begin
				state_d.tconst[i] = state_q.wData;  // see RULE14 RULE19
				if (mode == qpt_pkg::MODE_STOP) begin
					state_d.cnt[i] = state_q.wData;  // see RULE13 RULE5
				end
			end

			// output reset bit forces the A/B output low for the write
			if (i < 2 && doWrite && state_q.wLane0
					&& state_q.wData[qpt_pkg::CTRL_OUT_RESET_BIT]
					&& state_q.awAddr == ((i == 0) ? qpt_pkg::OFS_CTRL_A
						: qpt_pkg::OFS_CTRL_B)) begin
				state_d.tOut[i] = 1'b0;             // see RULE24
			end

			// holding register captures the live count every cycle
			state_d.hold[i] = state_q.cnt[i];       // see RULE12 RULE11
		end

		// baud clocks from the delay timers
		state_d.txClk = state_d.tOut[2];            // see RULE2
		state_d.rxClk = state_q.ctrlCD[qpt_pkg::CD_BAUD_SHARE_BIT]
			? state_d.tOut[2] : state_d.tOut[3];    // see RULE2

		// read channel: data registers return the held capture
		if (state_q.rvalid && axiReq.rready) begin
			state_d.rvalid = 1'b0;
		end
		if (axiReq.arvalid && state_q.arready) begin
			rdOk = 1'b1;
			case (axiReq.araddr)
				qpt_pkg::OFS_CTRL_A:   rdByte = {4'h0, state_q.ctrlA};
				qpt_pkg::OFS_CTRL_B:   rdByte = {4'h0, state_q.ctrlB};
				qpt_pkg::OFS_CTRL_CD:  rdByte = state_q.ctrlCD;
				qpt_pkg::OFS_DATA_A:   rdByte = state_q.hold[0];
				qpt_pkg::OFS_DATA_B:   rdByte = state_q.hold[1];
				qpt_pkg::OFS_DATA_C:   rdByte = state_q.hold[2];
				qpt_pkg::OFS_DATA_D:   rdByte = state_q.hold[3];
				qpt_pkg::OFS_EDGE_POL: rdByte = {6'h00, state_q.edgePol};
				default: begin
					rdOk   = 1'b0;
					rdByte = 8'h00;
				end
			endcase
			state_d.rvalid = 1'b1;
			state_d.rdata  = {24'h00_0000, rdByte}; // see RULE18
			state_d.rresp  = rdOk ? qpt_pkg::RESP_OKAY
				: qpt_pkg::RESP_DECERR;
		end
		state_d.arready = !state_d.rvalid;
	end

	// -----------------------------------------------------------------
	// state register; counts and constants survive reset
	// -----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			state_q.oscSync <= 3'h0;
			state_q.auxSync <= 6'h00;
			state_q.ctrlA   <= qpt_pkg::CTRL_RESET;
			state_q.ctrlB   <= qpt_pkg::CTRL_RESET;
			state_q.ctrlCD  <= qpt_pkg::CD_RESET;
			state_q.edgePol <= qpt_pkg::POL_RESET;
			state_q.presc   <= 32'h0000_0000;
			state_q.tOut    <= 4'h0;                // see RULE23
			state_q.tPulse  <= 4'h0;
			state_q.txClk   <= 1'b0;
			state_q.rxClk   <= 1'b0;
			state_q.oscOut  <= 1'b0;
			state_q.awHeld  <= 1'b0;
			state_q.awAddr  <= 32'h0000_0000;
			state_q.wHeld   <= 1'b0;
			state_q.wData   <= 8'h00;
			state_q.wLane0  <= 1'b0;
			state_q.awready <= 1'b0;
			state_q.wready  <= 1'b0;
			state_q.bvalid  <= 1'b0;
			state_q.bresp   <= qpt_pkg::RESP_OKAY;
			state_q.arready <= 1'b0;
			state_q.rvalid  <= 1'b0;
			state_q.rdata   <= 32'h0000_0000;
			state_q.rresp   <= qpt_pkg::RESP_OKAY;
		end else begin
			state_q <= state_d;
		end
	end

	// -----------------------------------------------------------------
	// outputs
	// -----------------------------------------------------------------
	assign axiRsp.awready = state_q.awready;
	assign axiRsp.wready  = state_q.wready;
	assign axiRsp.bvalid  = state_q.bvalid;
	assign axiRsp.bresp   = state_q.bresp;
	assign axiRsp.arready = state_q.arready;
	assign axiRsp.rvalid  = state_q.rvalid;
	assign axiRsp.rdata   = state_q.rdata;
	assign axiRsp.rresp   = state_q.rresp;
	assign timerOscOut    = state_q.oscOut;
	assign timerOut       = state_q.tOut;
	assign timeoutPulse   = state_q.tPulse;
	assign txBaudClk      = state_q.txClk;
	assign rxBaudClk      = state_q.rxClk;

endmodule : qpt_timers

// *** verif/qpt_pin_model.sv ***
// free running timer oscillator at the block's far side
// assumes the bench times time-outs by tickCount
module qpt_pin_model #(
	parameter int HALF_NS = 23 // half period, unrelated to clk_sys
) (
	output logic timerOscIn, // shared timer clock
	output int   tickCount   // rising edges issued so far
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		timerOscIn = 1'b0;
		tickCount = 0;
	end
	// one crystal clock feeds all four timers
	always #(HALF_NS) begin
		timerOscIn = ~timerOscIn;
		if (timerOscIn)
			tickCount++;
	end
endmodule : qpt_pin_model

// *** verif/qpt_timers_checker.sv ***
// concurrent checks on the quad timer ports
// assumes it is bound to qpt_timers and sees only its ports
module qpt_timers_checker (
	input wire logic                     clk_sys,      // system clock
	input wire logic                     nrst,         // async reset, low
	input wire qpt_pkg::qpt_axi_req_type axiReq,       // bus master side
	input wire qpt_pkg::qpt_axi_rsp_type axiRsp,       // bus slave side
	input wire logic                     timerOscIn,   // timer clock pin
	input wire logic                     timerOscOut,  // oscillator drive
	input wire logic                     timerAAuxIn,  // timer A aux pin
	input wire logic                     timerBAuxIn,  // timer B aux pin
	input wire logic [3:0]               timerOut,     // time-out outputs
	input wire logic [3:0]               timeoutPulse, // irq pulses
	input wire logic                     txBaudClk,    // serial tx clock
	input wire logic                     rxBaudClk     // serial rx clock
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk_sys);
	endclocking

	// a write is taken with address and data together
	sequence s_wr_take;
		axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
	endsequence
	// the answer two edges after the take
	sequence s_wr_answer;
		##2 axiRsp.bvalid;
	endsequence

	// bus answers with their fixed latencies
	a_write_answer: assert property (disable iff (!nrst)
		s_wr_take |-> s_wr_answer) else $error("write answer late");
	a_write_busy: assert property (disable iff (!nrst)
		s_wr_take |=> !axiRsp.awready && !axiRsp.wready)
		else $error("write ready not dropped");
	a_read_answer: assert property (disable iff (!nrst)
		axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
		else $error("read answer late");
	a_rdata_upper: assert property (disable iff (!nrst)
		axiRsp.rvalid |-> axiRsp.rdata[31:8] == 24'h0000_00)
		else $error("upper read data not zero");
	// time-out output against the time-out pulse of timer C
	a_toggle_pulse: assert property (disable iff (!nrst)
		timeoutPulse[2] |-> timerOut[2] != $past(timerOut[2]))
		else $error("output did not toggle on time-out");
	a_out_holds: assert property (disable iff (!nrst)
		$changed(timerOut[2]) |-> timeoutPulse[2])
		else $error("output changed without time-out");
	a_pulse_single: assert property (disable iff (!nrst)
		|timeoutPulse |=> (timeoutPulse & $past(timeoutPulse)) == 4'h0)
		else $error("time-out pulse longer than one cycle");
	a_tx_copy: assert property (disable iff (!nrst)
		$changed(timerOut[2]) |=> txBaudClk == $past(timerOut[2]))
		else $error("tx baud clock does not follow timer C");
	a_reset_low: assert property (
		!nrst ##1 !nrst |-> timerOut == 4'h0 && !axiRsp.bvalid)
		else $error("outputs not low in reset");
	// oscillator drive is the inverted pin, three edges late, once the
	// internal reset has let go of the synchroniser
	a_osc_drive: assert property (disable iff (!nrst)
		nrst [*6] |-> timerOscOut == !$past(timerOscIn, 3))
		else $error("oscillator drive does not follow pin");
endmodule : qpt_timers_checker

bind qpt_timers qpt_timers_checker chk (.clk_sys(clk_sys), .nrst(nrst),
	.axiReq(axiReq), .axiRsp(axiRsp), .timerOscIn(timerOscIn),
	.timerOscOut(timerOscOut), .timerAAuxIn(timerAAuxIn),
	.timerBAuxIn(timerBAuxIn), .timerOut(timerOut),
	.timeoutPulse(timeoutPulse), .txBaudClk(txBaudClk),
	.rxBaudClk(rxBaudClk));

// *** verif/test_quad_prescaled_down_timers.sv ***
// self-checking bench for the quad timer block
// assumes the pin model supplies the timer clock
module test_quad_prescaled_down_timers;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int DC = qpt_pkg::DIV_TABLE_DEFAULT[1]; // timer C divide
	localparam int DD = qpt_pkg::DIV_TABLE_DEFAULT[2]; // timer D divide
	logic                     clk_sys, nrst, auxA, auxB;
	logic                     osc, oscOut, txClk, rxClk;
	logic [3:0]               tOut, tPulse;
	logic [7:0]               rnd;
	logic [33:0]              note;
	logic [33:0]              expQ[$];
	qpt_pkg::qpt_axi_req_type req;
	qpt_pkg::qpt_axi_rsp_type rsp;
	int                       ticks, failures, compares, t0, t1, t2;

	qpt_timers uut (.clk_sys(clk_sys), .nrst(nrst), .axiReq(req),
		.axiRsp(rsp), .timerOscIn(osc), .timerOscOut(oscOut),
		.timerAAuxIn(auxA), .timerBAuxIn(auxB), .timerOut(tOut),
		.timeoutPulse(tPulse), .txBaudClk(txClk), .rxBaudClk(rxClk));
	qpt_pin_model osc_src (.timerOscIn(osc), .tickCount(ticks));

	// system clock
	always #2.5 clk_sys = ~clk_sys;

	task automatic print_verdict;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict

	task automatic check(input string what, input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic give_up(input string what);
		failures++;
		$display("Error %s expected done seen timeout", what);
		print_verdict();
	endtask : give_up

	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: {24'h0, d},
			wstrb: 4'hF, bready: 1'b1, default: '0};
		do begin
			@(posedge clk_sys);
			n++;
			if (rsp.awready)
				req.awvalid <= 1'b0;
			if (rsp.wready)
				req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1 && n < 50);
		req.bready <= 1'b0;
		if (n >= 50)
			give_up("write");
	endtask : wr

	task automatic rd(input logic [31:0] a, input logic [7:0] d,
		input logic [1:0] resp = qpt_pkg::RESP_OKAY);
		int n;
		n = 0;
		@(posedge clk_sys);
		expQ.push_back({resp, 24'h0000_00, d});
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (rsp.arready)
				req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1 && n < 50);
		req.rready <= 1'b0;
		if (n >= 50)
			give_up("read");
	endtask : rd

	task automatic wait_pulse(input int idx, output int t);
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (tPulse[idx] !== 1'b1 && n < 25000);
		if (n >= 25000)
			give_up("time-out pulse");
		t = ticks;
	endtask : wait_pulse

	task automatic period(input int idx, input int expT, input string what);
		int a, b;
		wait_pulse(idx, a);
		wait_pulse(idx, b);
		check(what, b - a, expT);
	endtask : period

	task automatic aux_edges(input int k);
		repeat (k) begin
			auxA <= 1'b1;
			repeat (40 + $urandom_range(20)) @(posedge clk_sys);
			auxA <= 1'b0;
			repeat (40 + $urandom_range(20)) @(posedge clk_sys);
		end
	endtask : aux_edges

	// watcher pairs each read answer with the oldest note
	always @(posedge clk_sys) begin
		if (rsp.rvalid === 1'b1 && req.rready === 1'b1) begin
			note = expQ.pop_front();
			check("rdata", rsp.rdata, note[31:0]);
			check("rresp", {30'h0, rsp.rresp},
				{30'h0, note[33:32]});
		end
	end

	// run limit
	initial begin
		#400us;
		give_up("run");
	end

	// main sequence
	initial begin
		clk_sys = 1'b0;
		nrst = 1'b0;
		auxA = 1'b0;
		auxB = 1'b0;
		req = '0;
		void'($urandom(32'h68FB_CA7B));
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rd(qpt_pkg::OFS_CTRL_A, 8'h00);
		rd(32'h0000_0020, 8'h00, qpt_pkg::RESP_DECERR);
		wr(qpt_pkg::OFS_CTRL_B, 8'hF0);
		rd(qpt_pkg::OFS_CTRL_B, 8'h00);
		rnd = 8'($urandom_range(255, 2));
		wr(qpt_pkg::OFS_DATA_A, rnd);
		repeat (100) @(posedge clk_sys);
		rd(qpt_pkg::OFS_DATA_A, rnd);
		$display("test registers done");
		wr(qpt_pkg::OFS_EDGE_POL, 8'h03);
		wr(qpt_pkg::OFS_DATA_A, 8'h03);
		wr(qpt_pkg::OFS_CTRL_A, 8'h08);
		aux_edges(1);
		rd(qpt_pkg::OFS_DATA_A, 8'h02);
		aux_edges(2);
		rd(qpt_pkg::OFS_DATA_A, 8'h03);
		check("out A", tOut[0], 1'b1);
		wr(qpt_pkg::OFS_CTRL_A, 8'h18);
		check("out A reset", tOut[0], 1'b0);
		$display("test event done");
		wr(qpt_pkg::OFS_DATA_B, 8'h02);
		wr(qpt_pkg::OFS_CTRL_B, 8'h09);
		repeat (200) @(posedge clk_sys);
		rd(qpt_pkg::OFS_DATA_B, 8'h02);
		auxB <= 1'b1;
		wait_pulse(1, t0);
		auxB <= 1'b0;
		check("out B", tOut[1], 1'b1);
		$display("test pulse width done");
		wr(qpt_pkg::OFS_DATA_C, 8'h01);
		wr(qpt_pkg::OFS_DATA_D, 8'h03);
		wr(qpt_pkg::OFS_CTRL_CD, 8'h12);
		period(2, DC, "period C");
		period(3, DD * 3, "period D");
		repeat (3) @(posedge clk_sys);
		check("rx baud D", rxClk, tOut[3]);
		wr(qpt_pkg::OFS_CTRL_CD, 8'h92);
		wait_pulse(2, t0);
		repeat (3) @(posedge clk_sys);
		check("rx baud C", rxClk, tOut[2]);
		wait_pulse(3, t0);
		// written just after a reload, far from a count of 01
		wr(qpt_pkg::OFS_DATA_D, 8'h05);
		wait_pulse(3, t1);
		wait_pulse(3, t2);
		check("old constant", t1 - t0, DD * 3);
		check("new constant", t2 - t1, DD * 5);
		wr(qpt_pkg::OFS_CTRL_CD, 8'h02);
		wr(qpt_pkg::OFS_DATA_C, 8'h00);
		wr(qpt_pkg::OFS_CTRL_CD, 8'h12);
		period(2, DC * 256, "period C max");
		$display("test delay done");
		wr(qpt_pkg::OFS_CTRL_CD, 8'h00);
		wr(qpt_pkg::OFS_DATA_C, 8'h77);
		repeat (200) @(posedge clk_sys);
		rd(qpt_pkg::OFS_DATA_C, 8'h77);
		nrst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		check("outs in reset", tOut, 4'h0);
		nrst <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rd(qpt_pkg::OFS_DATA_C, 8'h77);
		$display("test stop and reset done");
		print_verdict();
	end
endmodule : test_quad_prescaled_down_timers
